/* File: hdl/serial_port.sv */
// One asynchronous serial port with receive and transmit queues
`timescale 1ns/100ps
`include "serial_port_params.svh"

module serial_port #(
  parameter int RX_DEPTH      = `SP_RX_DEPTH,
  parameter bit IS_FIRST_PORT = 1'b0
) (
  // Clock and reset
  input  wire logic                      mclk_i,
  input  wire logic                      reset_n_i,
  // Register port
  input  wire serial_port_pkg::reg_req_t bus_i,
  output logic [15:0]                    rd_data_o,
  // System
  input  wire logic                      console_on_first_i,
  output logic                           irq_o,
  // Line pins
  input  wire logic                      rx_i,
  output logic                           tx_o,
  output logic                           tx_oe_o,
  output logic                           rx_pullup_en_o,
  output logic                           pins_claimed_o
);
  import serial_port_pkg::*;

  // Depths must be powers of two: pointers wrap by overflow
  localparam int TX_DEPTH = `SP_TX_DEPTH;
  localparam int RXW      = $clog2(RX_DEPTH);
  localparam int TXW      = $clog2(TX_DEPTH);

  // ****************************************************************
  // State
  // ****************************************************************
  ctrl_t            ctrl;
  logic [15:0]      divisor;
  logic [RXW:0]     trigger;
  status_t          status;
  status_t          mask;
  logic             port_open;
  logic [7:0]       tx_mem [TX_DEPTH];
  logic [TXW-1:0]   tx_wp;
  logic [TXW-1:0]   tx_rp;
  logic [TXW:0]     tx_cnt;
  logic [7:0]       rx_mem [RX_DEPTH];
  logic [RXW-1:0]   rx_wp;
  logic [RXW-1:0]   rx_rp;
  logic [RXW:0]     rx_cnt;
  tx_state_t        tx_state;
  logic [11:0]      tx_sh;
  logic [3:0]       tx_left;
  logic [15:0]      tx_tick;
  rx_state_t        rx_state;
  logic             rx_prev;
  logic [15:0]      rx_tick;
  logic [3:0]       rx_left;
  logic [8:0]       rx_sh;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  // Unmapped offsets match nothing: writes vanish, reads give zero
  wire wr_ctrl    = bus_i.wr && (bus_i.addr == `SP_REG_CTRL);
  wire wr_div     = bus_i.wr && (bus_i.addr == `SP_REG_DIVISOR);
  wire wr_txdata  = bus_i.wr && (bus_i.addr == `SP_REG_TXDATA);
  wire wr_trigger = bus_i.wr && (bus_i.addr == `SP_REG_TRIGGER);
  wire wr_status  = bus_i.wr && (bus_i.addr == `SP_REG_STATUS);
  wire wr_mask    = bus_i.wr && (bus_i.addr == `SP_REG_MASK);
  wire rd_rxdata  = bus_i.rd && (bus_i.addr == `SP_REG_RXDATA);

  // Out-of-range divisors are clamped rather than refused
  wire [15:0] div_w   = bus_i.wdata;
  wire [15:0] div_new = (div_w < `SP_DIV_MIN) ? `SP_DIV_MIN :
                        (div_w > `SP_DIV_MAX) ? `SP_DIV_MAX : div_w;

  // ****************************************************************
  // Open and close
  // ****************************************************************
  wire open_allowed = !(IS_FIRST_PORT && console_on_first_i);
  // Losing the console grant while open starts a close as well
  wire want_open    = ctrl.open_req && open_allowed;
  wire do_open      = !port_open && want_open;
  wire closing      = port_open && !want_open;
  wire tx_idle      = (tx_state == TX_IDLE);
  // Close completes only once the line has gone quiet
  wire close_done   = closing && (tx_cnt == '0) && tx_idle;

  // ****************************************************************
  // Queue control
  // ****************************************************************
  wire tx_full  = (tx_cnt == (TXW+1)'(TX_DEPTH));
  // A push during close is dropped; the queue only drains
  wire tx_push  = wr_txdata && port_open && !closing && !tx_full;
  wire tx_pop   = port_open && tx_idle && (tx_cnt != '0);
  wire rx_full  = (rx_cnt == (RXW+1)'(RX_DEPTH));
  wire rx_pop   = rd_rxdata && (rx_cnt != '0);
  wire rx_done  = (rx_state == RX_STOP) && (rx_tick == '0);
  wire rx_push  = rx_done && port_open;
  // Full queue on arrival: read side advances too, losing the oldest
  wire rx_drop  = rx_push && rx_full && !rx_pop;
  // Empty queue reads as zero, never a stale slot
  wire [7:0] rx_head = (rx_cnt != '0) ? rx_mem[rx_rp] : 8'h00;

  wire [TXW:0] tx_cnt_nx = tx_cnt + (TXW+1)'(tx_push) - (TXW+1)'(tx_pop);
  wire [RXW:0] rx_cnt_nx = rx_cnt + (RXW+1)'(rx_push && !rx_drop) - (RXW+1)'(rx_pop);

  // ****************************************************************
  // Character format
  // ****************************************************************
  wire [3:0] data_bits = ctrl.seven_bit_option ? 4'h7 : 4'h8;
  wire [3:0] field_len = data_bits + {3'h0, ctrl.parity_en};
  wire [3:0] stop_bits = ctrl.two_stop_option ? 4'h2 : 4'h1;

  wire [7:0] tx_byte  = tx_mem[tx_rp];
  // Seven-bit mode ignores the top bit of a written character
  wire [7:0] tx_data  = ctrl.seven_bit_option ? {1'b0, tx_byte[6:0]} : tx_byte;
  // Odd flips the even-parity bit
  wire       tx_par   = (^tx_data) ^ ctrl.parity_odd;
  wire       tx_pbit  = ctrl.parity_en ? tx_par : 1'b1;
  wire [8:0] tx_field = ctrl.seven_bit_option ? {1'b1, tx_pbit, tx_data[6:0]}
                                              : {tx_pbit, tx_data};
  // Start low, then data LSB first, ones fill parity-less and stop slots
  wire [11:0] tx_frame = {2'b11, tx_field, 1'b0};
  wire [3:0]  tx_total = 4'h1 + field_len + stop_bits;
  wire        tx_level = (tx_state == TX_SHIFT) ? tx_sh[0] : 1'b1;

  wire [8:0] rx_align = rx_sh >> (4'h9 - field_len);
  wire [7:0] rx_data  = ctrl.seven_bit_option ? {1'b0, rx_align[6:0]} : rx_align[7:0];
  wire       rx_pbit  = ctrl.seven_bit_option ? rx_align[7] : rx_align[8];
  wire       rx_perr  = ctrl.parity_en && ((^rx_data) ^ rx_pbit ^ ctrl.parity_odd);

  // ****************************************************************
  // Events
  // ****************************************************************
  // Not raised in the closing cycle, so the cancel below cannot be undone
  wire ev_trigger = port_open && !close_done && ctrl.rx_notify_en && (trigger != '0)
                    && (rx_cnt >= trigger);
  wire status_t events = '{frame_err:   rx_push && !rx_i,
                           parity_err:  rx_push && rx_perr,
                           rx_overflow: rx_drop,
                           rx_trigger:  ev_trigger};
  wire status_t w1c    = wr_status ? status_t'(bus_i.wdata[`SP_STATUS_MSB:0]) : '0;
  wire [`SP_STATUS_MSB:0] ev_bits  = events;
  wire [`SP_STATUS_MSB:0] clr_bits = w1c | {3'b000, close_done};
  wire [`SP_STATUS_MSB:0] st_bits  = status;
  wire [`SP_STATUS_MSB:0] next_bits;

  // Set beats clear; close cancels a pending rx_trigger event only
  genvar gi;
  generate
    for (gi = 0; gi <= `SP_STATUS_MSB; gi++) begin : g_status
      assign next_bits[gi] = ev_bits[gi] || (st_bits[gi] && !clr_bits[gi]);
    end
  endgenerate
  wire status_t next_status = status_t'(next_bits);

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire [15:0] rd_mux =
    (bus_i.addr == `SP_REG_CTRL)    ? {8'h00, ctrl} :
    (bus_i.addr == `SP_REG_DIVISOR) ? divisor :
    (bus_i.addr == `SP_REG_TXDATA)  ? 16'(TX_DEPTH) - 16'(tx_cnt) :
    (bus_i.addr == `SP_REG_RXDATA)  ? {8'h00, rx_head} :
    (bus_i.addr == `SP_REG_RXCOUNT) ? 16'(rx_cnt) :
    (bus_i.addr == `SP_REG_TRIGGER) ? 16'(trigger) :
    (bus_i.addr == `SP_REG_STATUS)  ? {12'h000, status} :
    (bus_i.addr == `SP_REG_MASK)    ? {12'h000, mask} :
    (bus_i.addr == `SP_REG_STATE)   ? {13'h0000, closing, !tx_idle, port_open} :
                                      16'h0000;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ctrl    <= ctrl_t'(`SP_CTRL_RESET);
      divisor <= `SP_DIV_DEFAULT;
      trigger <= '0;
      mask    <= status_t'(`SP_STATUS_RESET);
      status  <= status_t'(`SP_STATUS_RESET);
    end else begin
      if (wr_ctrl)    ctrl    <= ctrl_t'(bus_i.wdata[`SP_CTRL_MSB:`SP_CTRL_LSB]);
      if (wr_div)     divisor <= div_new;
      if (wr_trigger) trigger <= bus_i.wdata[RXW:0];
      if (wr_mask)    mask    <= status_t'(bus_i.wdata[`SP_STATUS_MSB:0]);
      status <= next_status;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      port_open <= 1'b0;
    end else if (do_open) begin
      port_open <= 1'b1;
    end else if (close_done) begin
      port_open <= 1'b0;
    end
  end

  // ****************************************************************
  // Queues
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (tx_push) tx_mem[tx_wp] <= bus_i.wdata[7:0];
    if (rx_push) rx_mem[rx_wp] <= rx_data;
  end

  // Opening flushes both queues so no character outlives a session
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || do_open) begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= '0;
      rx_wp  <= '0;
      rx_rp  <= '0;
      rx_cnt <= '0;
    end else begin
      if (tx_push)          tx_wp <= tx_wp + 1'b1;
      if (tx_pop)           tx_rp <= tx_rp + 1'b1;
      if (rx_push)          rx_wp <= rx_wp + 1'b1;
      if (rx_pop || rx_drop) rx_rp <= rx_rp + 1'b1;
      tx_cnt <= tx_cnt_nx;
      rx_cnt <= rx_cnt_nx;
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  // The idle clock between characters stretches the last stop bit by one
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tx_state <= TX_IDLE;
      tx_sh    <= '1;
      tx_left  <= '0;
      tx_tick  <= '0;
    end else begin
      unique case (tx_state)
        TX_IDLE: if (tx_pop) begin
          tx_state <= TX_SHIFT;
          tx_sh    <= tx_frame;
          tx_left  <= tx_total;
          tx_tick  <= divisor - 16'h0001;
        end
        TX_SHIFT: if (tx_tick == '0) begin
          tx_sh   <= {1'b1, tx_sh[11:1]};
          tx_left <= tx_left - 4'h1;
          tx_tick <= divisor - 16'h0001;
          if (tx_left == 4'h1) tx_state <= TX_IDLE;
        end else begin
          tx_tick <= tx_tick - 16'h0001;
        end
      endcase
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  // A frame cut by a close is finished on the line but never queued
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rx_state <= RX_IDLE;
      rx_prev  <= 1'b1;
      rx_tick  <= '0;
      rx_left  <= '0;
      rx_sh    <= '0;
    end else begin
      rx_prev <= rx_i;
      unique case (rx_state)
        // Each start edge restarts the bit timing
        RX_IDLE: if (port_open && rx_prev && !rx_i) begin
          rx_state <= RX_START;
          rx_tick  <= divisor >> 1;
        end
        // A start bit that is high again at its centre was a glitch
        RX_START: if (rx_tick == '0) begin
          rx_state <= rx_i ? RX_IDLE : RX_DATA;
          rx_left  <= field_len;
          rx_tick  <= divisor - 16'h0001;
        end else begin
          rx_tick <= rx_tick - 16'h0001;
        end
        RX_DATA: if (rx_tick == '0) begin
          rx_sh   <= {rx_i, rx_sh[8:1]};
          rx_left <= rx_left - 4'h1;
          rx_tick <= divisor - 16'h0001;
          if (rx_left == 4'h1) rx_state <= RX_STOP;
        end else begin
          rx_tick <= rx_tick - 16'h0001;
        end
        // Only the first stop bit is checked; a second one is idle time
        RX_STOP: if (rx_tick == '0) begin
          rx_state <= RX_IDLE;
        end else begin
          rx_tick <= rx_tick - 16'h0001;
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rd_data_o      <= '0;
      irq_o          <= 1'b0;
      tx_o           <= 1'b1;
      tx_oe_o        <= 1'b0;
      rx_pullup_en_o <= 1'b0;
      pins_claimed_o <= 1'b0;
    end else begin
      rd_data_o      <= bus_i.rd ? rd_mux : 16'h0000;
      irq_o          <= |(next_status & mask);
      // Open-drain pin is only ever pulled low; the pull-up gives the high
      tx_o           <= ctrl.open_drain_tx_option ? 1'b0 : tx_level;
      tx_oe_o        <= port_open && (!ctrl.open_drain_tx_option || !tx_level);
      rx_pullup_en_o <= port_open && !ctrl.pullup_disable;
      pins_claimed_o <= port_open;
    end
  end

endmodule : serial_port

/* File: common/serial_port_params.svh */
// Offsets, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define SP_CLK_HZ        40000000
`define SP_BAUD_DEFAULT  9600
`define SP_BAUD_MIN      2400
`define SP_BAUD_MAX      1800000
`define SP_DIV_DEFAULT   16'(`SP_CLK_HZ / `SP_BAUD_DEFAULT)
`define SP_DIV_MAX       16'(`SP_CLK_HZ / `SP_BAUD_MIN)
`define SP_DIV_MIN       16'(`SP_CLK_HZ / `SP_BAUD_MAX)

// ****************************************************************
// Queue sizes
// ****************************************************************
`define SP_RX_DEPTH      256
`define SP_TX_DEPTH      256

// ****************************************************************
// Register offsets
// ****************************************************************
`define SP_REG_CTRL      4'h0
`define SP_REG_DIVISOR   4'h1
`define SP_REG_TXDATA    4'h2
`define SP_REG_RXDATA    4'h3
`define SP_REG_RXCOUNT   4'h4
`define SP_REG_TRIGGER   4'h5
`define SP_REG_STATUS    4'h6
`define SP_REG_MASK      4'h7
`define SP_REG_STATE     4'h8

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SP_CTRL_LSB      0
`define SP_CTRL_MSB      7
`define SP_STATUS_MSB    3
`define SP_CTRL_RESET    8'h00
`define SP_STATUS_RESET  4'h0

`endif

/* File: common/serial_port_pkg.sv */
// Types shared by the serial port and its bench
package serial_port_pkg;

  // Control word, top bit first
  typedef struct packed {
    logic rx_notify_en;
    logic pullup_disable;
    logic open_drain_tx_option;
    logic two_stop_option;
    logic parity_odd;
    logic parity_en;
    logic seven_bit_option;
    logic open_req;
  } ctrl_t;

  // Sticky event bits, top bit first
  typedef struct packed {
    logic frame_err;
    logic parity_err;
    logic rx_overflow;
    logic rx_trigger;
  } status_t;

  // Register request from software
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

endpackage : serial_port_pkg

/* File: bench/serial_port_properties.sv */
// Concurrent checks on the serial port pins and register port
`timescale 1ns/100ps

module serial_port_properties #(
  parameter int RX_DEPTH      = 256,
  parameter bit IS_FIRST_PORT = 1'b0
) (
  // Clock and reset
  input wire logic                      mclk_i,
  input wire logic                      reset_n_i,
  // Register port and system
  input wire serial_port_pkg::reg_req_t bus_i,
  input wire logic [15:0]               rd_data_o,
  input wire logic                      console_on_first_i,
  input wire logic                      irq_o,
  // Line pins
  input wire logic                      rx_i,
  input wire logic                      tx_o,
  input wire logic                      tx_oe_o,
  input wire logic                      rx_pullup_en_o,
  input wire logic                      pins_claimed_o
);
  import serial_port_pkg::*;
  // ****************************************************************
  // Properties
  // ****************************************************************
  // Released pin floats high through the external pull-up
  wire line = tx_oe_o ? tx_o : 1'b1;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  property p_low_bit_length;
    $fell(line) |-> (line == 1'b0) [*8];
  endproperty
  a_low_bit_length: assert property (p_low_bit_length) else $error("low bit too short");
  property p_open_walk;
    bus_i.wr && bus_i.addr == 4'h0 && bus_i.wdata[0] && !(IS_FIRST_PORT && console_on_first_i)
      |-> ##3 pins_claimed_o;
  endproperty
  a_open_walk: assert property (p_open_walk) else $error("port did not open");
  property p_console_lock;
    IS_FIRST_PORT && console_on_first_i && !pins_claimed_o |=> !pins_claimed_o;
  endproperty
  a_console_lock: assert property (p_console_lock) else $error("opened under console");
  property p_drive_only_open;
    tx_oe_o |-> pins_claimed_o;
  endproperty
  a_drive_only_open: assert property (p_drive_only_open) else $error("tx driven closed");
  property p_pullup_only_open;
    rx_pullup_en_o |-> pins_claimed_o;
  endproperty
  a_pullup_only_open: assert property (p_pullup_only_open) else $error("pullup closed");
  property p_close_release;
    $fell(pins_claimed_o) |-> !tx_oe_o && !rx_pullup_en_o;
  endproperty
  a_close_release: assert property (p_close_release) else $error("pins kept");
  property p_mask_off;
    bus_i.wr && bus_i.addr == 4'h7 && bus_i.wdata[3:0] == 4'h0 |-> ##2 !irq_o;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq while all masked");
  property p_rd_quiet;
    (!bus_i.rd || bus_i.addr > 4'h8) |=> rd_data_o == 16'h0000;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero");
endmodule : serial_port_properties

/* File: bench/remote_serial_node.sv */
// Remote serial node on the far end of the line
`timescale 1ns/100ps

module remote_serial_node (
  // Clock
  input  wire logic mclk_i,
  // Line
  input  wire logic line_i,
  output logic      rx_o
);
  int          bit_cycles = 22;
  int          frame_len  = 10;
  logic [11:0] got [$];

  initial rx_o = 1'b1;

  // Caller supplies parity and stop levels, so bad frames are possible
  task automatic send(input logic [11:0] bits, input int n);
    rx_o <= 1'b0;
    repeat (bit_cycles) @(posedge mclk_i);
    for (int i = 0; i < n; i++) begin
      rx_o <= bits[i];
      repeat (bit_cycles) @(posedge mclk_i);
    end
    rx_o <= 1'b1;
    repeat (bit_cycles) @(posedge mclk_i);
  endtask : send

  // Samples bit centres, lsb first, after the first low level
  always begin : capture
    logic [11:0] w;
    @(posedge mclk_i iff line_i === 1'b0);
    w = '0;
    repeat (bit_cycles / 2) @(posedge mclk_i);
    for (int i = 0; i < frame_len; i++) begin
      repeat (bit_cycles) @(posedge mclk_i);
      w[i] = line_i;
    end
    got.push_back(w);
  end
endmodule : remote_serial_node

/* File: bench/tb_configurable_async_serial_port.sv */
// Self-checking bench for the serial port against a remote node
`timescale 1ns/100ps
`include "serial_port_params.svh"

module tb_configurable_async_serial_port;
  import serial_port_pkg::*;
  logic        mclk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  reg_req_t    bus = '0;
  logic        console = 1'b0;
  logic [15:0] rd_data_o;
  logic        irq_o, rx_i, tx_o, tx_oe_o, rx_pullup_en_o, pins_claimed_o;
  int          fails = 0;
  int          n_checks = 0;
  logic [7:0]  cfgs [4] = '{8'h01, 8'h07, 8'h1d, 8'h2f};
  wire         tx_line = tx_oe_o ? tx_o : 1'b1;

  always #12.5 mclk_i = ~mclk_i;

  serial_port #(.RX_DEPTH(4), .IS_FIRST_PORT(1'b1)) u_serial_port (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_i(bus), .rd_data_o(rd_data_o),
    .console_on_first_i(console), .irq_o(irq_o), .rx_i(rx_i), .tx_o(tx_o),
    .tx_oe_o(tx_oe_o), .rx_pullup_en_o(rx_pullup_en_o), .pins_claimed_o(pins_claimed_o));
  remote_serial_node u_remote (.mclk_i(mclk_i), .line_i(tx_line), .rx_o(rx_i));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus <= '0;
    @(posedge mclk_i);
  endtask : wr
  task automatic rdchk(input string what, input logic [3:0] a, input logic [15:0] exp);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus <= '0;
    #1 check(what, rd_data_o, exp);
    @(posedge mclk_i);
  endtask : rdchk
  task automatic wait_closed;
    for (int i = 0; i < 4000 && pins_claimed_o !== 1'b0; i++) @(posedge mclk_i);
  endtask : wait_closed
  function automatic logic [11:0] frame(input logic [7:0] c, input logic [7:0] d);
    ctrl_t       k;
    int          n;
    logic [11:0] w;
    k = ctrl_t'(c);
    n = k.seven_bit_option ? 7 : 8;
    w = 12'(d) & ((12'h001 << n) - 12'h001);
    if (k.parity_en) begin
      w[n] = ^w ^ k.parity_odd;
      n++;
    end
    w[n] = 1'b1;
    if (k.two_stop_option) w[n+1] = 1'b1;
    return w;
  endfunction : frame
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_setup;
    check("idle line", {15'h0, tx_line}, 16'h0001);
    rdchk("ctrl", `SP_REG_CTRL, 16'h0000);
    rdchk("divisor", `SP_REG_DIVISOR, 16'h1046);
    rdchk("tx free", `SP_REG_TXDATA, 16'h0100);
    rdchk("unmapped", 4'hf, 16'h0000);
    wr(`SP_REG_DIVISOR, 16'h0001);
    rdchk("div fast", `SP_REG_DIVISOR, 16'h0016);
    wr(`SP_REG_DIVISOR, 16'hffff);
    rdchk("div slow", `SP_REG_DIVISOR, 16'h411a);
    wr(`SP_REG_DIVISOR, 16'h0016);
    $display("test setup done");
  endtask : t_setup
  task automatic t_tx;
    logic [7:0] c;
    for (int k = 0; k < 4; k++) begin
      c = cfgs[k];
      u_remote.frame_len = (c[1] ? 7 : 8) + c[2] + 1 + c[4];
      u_remote.got.delete();
      wr(`SP_REG_CTRL, {8'h00, c});
      rdchk("open", `SP_REG_STATE, 16'h0001);
      check("oe", {15'h0, tx_oe_o}, {15'h0, ~c[5]});
      check("pullup", {15'h0, rx_pullup_en_o}, 16'h0001);
      wr(`SP_REG_TXDATA, 16'h00b5);
      wr(`SP_REG_TXDATA, 16'h004e);
      wr(`SP_REG_CTRL, {8'h00, c & 8'hfe});
      rdchk("closing", `SP_REG_STATE, 16'h0007);
      if (c[5]) check("od level", {15'h0, tx_o}, 16'h0000);
      wait_closed();
      check("frames", 16'(u_remote.got.size()), 16'h0002);
      check("frame0", {4'h0, u_remote.got[0]}, {4'h0, frame(c, 8'hb5)});
      check("frame1", {4'h0, u_remote.got[1]}, {4'h0, frame(c, 8'h4e)});
      check("oe off", {15'h0, tx_oe_o}, 16'h0000);
      check("pullup off", {15'h0, rx_pullup_en_o}, 16'h0000);
    end
    $display("test tx done");
  endtask : t_tx
  task automatic t_rx;
    wr(`SP_REG_TRIGGER, 16'h0002);
    wr(`SP_REG_MASK, 16'h0001);
    wr(`SP_REG_CTRL, 16'h0081);
    u_remote.send(12'h13c, 9);
    rdchk("count one", `SP_REG_RXCOUNT, 16'h0001);
    check("irq early", {15'h0, irq_o}, 16'h0000);
    u_remote.send(12'h1a5, 9);
    rdchk("count two", `SP_REG_RXCOUNT, 16'h0002);
    check("irq level", {15'h0, irq_o}, 16'h0001);
    rdchk("rx first", `SP_REG_RXDATA, 16'h003c);
    rdchk("rx second", `SP_REG_RXDATA, 16'h00a5);
    wr(`SP_REG_STATUS, 16'h0001);
    rdchk("status clear", `SP_REG_STATUS, 16'h0000);
    check("irq clear", {15'h0, irq_o}, 16'h0000);
    wr(`SP_REG_CTRL, 16'h0045);
    u_remote.send(12'h001, 10);
    check("pullup disabled", {15'h0, rx_pullup_en_o}, 16'h0000);
    rdchk("bad frame", `SP_REG_STATUS, 16'h000c);
    rdchk("bad char", `SP_REG_RXDATA, 16'h0001);
    wr(`SP_REG_CTRL, 16'h000f);
    u_remote.send(12'h1b5, 9);
    rdchk("rx seven", `SP_REG_RXDATA, 16'h0035);
    wr(`SP_REG_CTRL, 16'h0001);
    for (int i = 0; i < 5; i++) u_remote.send({4'h1, 8'(8'h10 + i)}, 9);
    rdchk("depth", `SP_REG_RXCOUNT, 16'h0004);
    rdchk("oldest gone", `SP_REG_RXDATA, 16'h0011);
    rdchk("overflow", `SP_REG_STATUS, 16'h000e);
    check("irq masked", {15'h0, irq_o}, 16'h0000);
    wr(`SP_REG_MASK, 16'h0002);
    rdchk("mask", `SP_REG_MASK, 16'h0002);
    check("irq unmasked", {15'h0, irq_o}, 16'h0001);
    wr(`SP_REG_MASK, 16'h0000);
    wr(`SP_REG_STATUS, 16'h000f);
    rdchk("all clear", `SP_REG_STATUS, 16'h0000);
    check("irq off", {15'h0, irq_o}, 16'h0000);
    wr(`SP_REG_CTRL, 16'h0081);
    rdchk("event pending", `SP_REG_STATUS, 16'h0001);
    wr(`SP_REG_CTRL, 16'h0080);
    wait_closed();
    check("closed", {15'h0, pins_claimed_o}, 16'h0000);
    rdchk("event cancelled", `SP_REG_STATUS, 16'h0000);
    $display("test rx done");
  endtask : t_rx
  task automatic t_console;
    console <= 1'b1;
    wr(`SP_REG_CTRL, 16'h0001);
    rdchk("refused", `SP_REG_STATE, 16'h0000);
    check("unclaimed", {15'h0, pins_claimed_o}, 16'h0000);
    wr(`SP_REG_CTRL, 16'h0000);
    console <= 1'b0;
    $display("test console done");
  endtask : t_console

  initial begin
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    t_setup();
    t_tx();
    t_rx();
    t_console();
    stop_test();
  end
  initial begin : watchdog
    repeat (30000) @(posedge mclk_i);
    fails++;
    stop_test();
  end
endmodule : tb_configurable_async_serial_port

bind serial_port serial_port_properties #(
  .RX_DEPTH(RX_DEPTH), .IS_FIRST_PORT(IS_FIRST_PORT)
) u_serial_port_properties (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
  .console_on_first_i(console_on_first_i), .irq_o(irq_o), .rx_i(rx_i), .tx_o(tx_o),
  .tx_oe_o(tx_oe_o), .rx_pullup_en_o(rx_pullup_en_o), .pins_claimed_o(pins_claimed_o));
